// ===== src/cdf_pkg.sv
// Package: op-codes, field layout, reset values and timing of the divider and flag block
package cdf_pkg;
  // Op-codes
  localparam logic [7:0] DIVIDER_WRITE_OPCODE = 8'h38;
  localparam logic [7:0] DIVIDER_READ_OPCODE = 8'hD4;
  localparam logic [7:0] ASSIGNMENT_WRITE_OPCODE = 8'h34;
  localparam logic [7:0] ASSIGNMENT_READ_OPCODE = 8'hD0;
  localparam logic [7:0] MASTER_RESET_OPCODE = 8'h04;
  // Field layout
  localparam logic [7:0] DIV_WRITE_MASK = 8'h1E;
  localparam int DIV_LSB = 1;
  localparam int RX2_EVT_LSB = 6;
  localparam int RX2_LVL_LSB = 4;
  localparam int RX1_EVT_LSB = 2;
  localparam int RX1_LVL_LSB = 0;
  // Reset values
  localparam logic [7:0] DIV_RESET = 8'h00;
  localparam logic [7:0] ASSIGN_RESET = 8'h00;
  // FIFO levels
  localparam logic [5:0] FIFO_FULL_LEVEL = 6'h20;
  localparam logic [5:0] FIFO_HALF_LEVEL = 6'h10;
  // Timing
  localparam int CLK_MHZ = 100;
  localparam int TICK_US = 1;
  localparam int TICK_CYCLES = CLK_MHZ * TICK_US;
  localparam int PULSE_NS = 500;
  localparam int PULSE_CYCLES = (PULSE_NS * CLK_MHZ) / 1000;
  localparam logic [7:0] PULSE_COUNT = 8'(PULSE_CYCLES);
  // Encodings
  typedef enum logic [1:0] {CDF_SRC_ANY, CDF_SRC_MB1, CDF_SRC_MB2, CDF_SRC_MB3} cdf_evt_sel_t;
endpackage : cdf_pkg

// ===== src/cdf_rx_out.sv
// One receiver's event pulse and level pin generator
`timescale 1ns/1ns
module cdf_rx_out (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  input wire logic soft_clear,
  // Selection
  input wire logic [1:0] evt_sel,
  input wire logic [1:0] lvl_sel,
  // Receiver status
  input wire logic [5:0] fifo_level,
  input wire logic word_stored,
  input wire logic [2:0] mailbox_capture,
  // Pins
  output logic event_pin,
  output logic level_pin
);
  import cdf_pkg::*;

  logic [7:0] cnt_q, cnt_d;
  logic lvl_q, lvl_d;
  logic trig;

  always_comb begin
    case (cdf_evt_sel_t'(evt_sel))
      CDF_SRC_ANY: trig = word_stored | (|mailbox_capture);
      CDF_SRC_MB1: trig = mailbox_capture[0];
      CDF_SRC_MB2: trig = mailbox_capture[1];
      CDF_SRC_MB3: trig = mailbox_capture[2];
      default: trig = 1'b0;
    endcase
    // A new event restarts the full pulse width
    if (soft_clear) begin
      cnt_d = 8'h00;
    end else if (trig) begin
      cnt_d = PULSE_COUNT;
    end else if (cnt_q != 8'h00) begin
      cnt_d = cnt_q - 8'h01;
    end else begin
      cnt_d = cnt_q;
    end
    case (lvl_sel)
      2'b00: lvl_d = (fifo_level == 6'h00);
      2'b01: lvl_d = (fifo_level >= FIFO_FULL_LEVEL);
      2'b10: lvl_d = (fifo_level >= FIFO_HALF_LEVEL);
      2'b11: lvl_d = (fifo_level != 6'h00);
      default: lvl_d = 1'b0;
    endcase
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cnt_q <= 8'h00;
      lvl_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      lvl_q <= lvl_d;
    end
  end

  assign event_pin = (cnt_q != 8'h00);
  assign level_pin = lvl_q;

  chk_pulse_width: assert property (@(posedge clk) disable iff (!nrst)
    (trig && !soft_clear) |=> event_pin [*8] ##1 event_pin [*8])
    else $error("event pulse shorter than width");
  chk_level_track: assert property (@(posedge clk) disable iff (!nrst)
    (lvl_sel == 2'b00 && fifo_level == 6'h00) |=> level_pin)
    else $error("empty flag not raised");
endmodule : cdf_rx_out

// ===== src/cdf_top.sv
// Clock divide setting, flag/interrupt assignment, timebase and receiver pins
// Behaviour
// - Divide setting bits 7,6,5,0 ignore writes and read zero.
// - Divide ratio field in bits 4:1, zero after reset.
// - Host writes input MHz; device divides input clock by that ratio.
// - Op-code 0x38 writes divide setting, 0xD4 reads it.
// - Op-code 0x34 writes assignment setting, 0xD0 reads it.
// - Bits 7:6 pick receiver-2 event pulse source: any word or mailbox, mailbox 1, 2, 3.
// - Bits 3:2 pick receiver-1 event pulse source, same encoding.
// - Bits 5:4 pick receiver-2 level: empty, full, half, not empty.
// - Bits 1:0 pick receiver-1 level, same encoding.
// - Divider derives a 1 MHz timebase using the programmed ratio.
// - Master reset pin or op-code 0x04 clears both settings; soft reset not.
`timescale 1ns/1ns
module cdf_top (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  input wire logic master_reset_pin,
  input wire logic soft_reset,
  // Decoded command port
  input wire logic cmd_valid,
  input wire logic [7:0] cmd_opcode,
  input wire logic [7:0] cmd_wdata,
  output logic [7:0] cmd_rdata,
  output logic cmd_rvalid,
  // Reference clock, sampled as a level
  input wire logic ref_clk_in,
  output logic timebase_tick,
  // Receiver status
  input wire logic [5:0] rx_one_fifo_level,
  input wire logic rx_one_word_stored,
  input wire logic [2:0] rx_one_mailbox,
  input wire logic [5:0] rx_two_fifo_level,
  input wire logic rx_two_word_stored,
  input wire logic [2:0] rx_two_mailbox,
  // Pins
  output logic rx_one_event_pin,
  output logic rx_two_event_pin,
  output logic rx_one_level_pin,
  output logic rx_two_level_pin,
  // Settings
  output logic [7:0] clock_divide_setting,
  output logic [7:0] flag_interrupt_assignment
);
  import cdf_pkg::*;

  logic [7:0] div_q, div_d;
  logic [7:0] asg_q, asg_d;
  logic [7:0] rdata_q, rdata_d;
  logic rvalid_q, rvalid_d;
  logic master_clr;
  logic ref_q, ref_d;
  logic [4:0] edge_cnt_q, edge_cnt_d;
  logic tick_q, tick_d;
  logic [4:0] ratio;
  logic ref_rise;

  // Master reset by pin or command; a soft reset leaves settings alone
  assign master_clr = master_reset_pin
    || (cmd_valid && cmd_opcode == MASTER_RESET_OPCODE);

  always_comb begin
    div_d = div_q;
    asg_d = asg_q;
    rdata_d = rdata_q;
    rvalid_d = 1'b0;
    if (master_clr) begin
      div_d = DIV_RESET;
      asg_d = ASSIGN_RESET;
    end else if (cmd_valid) begin
      case (cmd_opcode)
        DIVIDER_WRITE_OPCODE: div_d = cmd_wdata & DIV_WRITE_MASK;
        ASSIGNMENT_WRITE_OPCODE: asg_d = cmd_wdata;
        DIVIDER_READ_OPCODE: begin
          rdata_d = div_q;
          rvalid_d = 1'b1;
        end
        ASSIGNMENT_READ_OPCODE: begin
          rdata_d = asg_q;
          rvalid_d = 1'b1;
        end
        default: rvalid_d = 1'b0;
      endcase
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      div_q <= DIV_RESET;
      asg_q <= ASSIGN_RESET;
      rdata_q <= 8'h00;
      rvalid_q <= 1'b0;
    end else begin
      div_q <= div_d;
      asg_q <= asg_d;
      rdata_q <= rdata_d;
      rvalid_q <= rvalid_d;
    end
  end

  assign cmd_rdata = rdata_q;
  assign cmd_rvalid = rvalid_q;
  assign clock_divide_setting = div_q;
  assign flag_interrupt_assignment = asg_q;

  // Ratio equals bits 4:0 of the byte; zero means the input already runs at 1 MHz
  assign ratio = (div_q[4:0] == 5'h00) ? 5'h01 : div_q[4:0];
  assign ref_rise = ref_clk_in && !ref_q;

  // Count rising edges of the reference input; one tick per ratio edges
  always_comb begin
    ref_d = ref_clk_in;
    edge_cnt_d = edge_cnt_q;
    tick_d = 1'b0;
    if (master_clr) begin
      edge_cnt_d = 5'h00;
    end else if (ref_rise) begin
      if (edge_cnt_q + 5'h01 >= ratio) begin
        edge_cnt_d = 5'h00;
        tick_d = 1'b1;
      end else begin
        edge_cnt_d = edge_cnt_q + 5'h01;
      end
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ref_q <= 1'b0;
      edge_cnt_q <= 5'h00;
      tick_q <= 1'b0;
    end else begin
      ref_q <= ref_d;
      edge_cnt_q <= edge_cnt_d;
      tick_q <= tick_d;
    end
  end

  assign timebase_tick = tick_q;

  cdf_rx_out u_rx_one (
    .clk(clk),
    .nrst(nrst),
    .soft_clear(master_clr),
    .evt_sel(asg_q[RX1_EVT_LSB +: 2]),
    .lvl_sel(asg_q[RX1_LVL_LSB +: 2]),
    .fifo_level(rx_one_fifo_level),
    .word_stored(rx_one_word_stored),
    .mailbox_capture(rx_one_mailbox),
    .event_pin(rx_one_event_pin),
    .level_pin(rx_one_level_pin)
  );

  cdf_rx_out u_rx_two (
    .clk(clk),
    .nrst(nrst),
    .soft_clear(master_clr),
    .evt_sel(asg_q[RX2_EVT_LSB +: 2]),
    .lvl_sel(asg_q[RX2_LVL_LSB +: 2]),
    .fifo_level(rx_two_fifo_level),
    .word_stored(rx_two_word_stored),
    .mailbox_capture(rx_two_mailbox),
    .event_pin(rx_two_event_pin),
    .level_pin(rx_two_level_pin)
  );

  // Command steps that the checks below start from
  sequence s_div_write;
    cmd_valid && cmd_opcode == DIVIDER_WRITE_OPCODE && !master_reset_pin;
  endsequence

  sequence s_div_read;
    cmd_valid && cmd_opcode == DIVIDER_READ_OPCODE && !master_reset_pin;
  endsequence

  sequence s_asg_write;
    cmd_valid && cmd_opcode == ASSIGNMENT_WRITE_OPCODE && !master_reset_pin;
  endsequence

  sequence s_asg_read;
    cmd_valid && cmd_opcode == ASSIGNMENT_READ_OPCODE && !master_reset_pin;
  endsequence

  chk_div_masked: assert property (@(posedge clk) disable iff (!nrst)
    s_div_write |=> (div_q == ($past(cmd_wdata) & DIV_WRITE_MASK)))
    else $error("divide setting not masked");
  chk_div_zero_bits: assert property (@(posedge clk) disable iff (!nrst)
    (div_q[7:5] == 3'b000) && !div_q[0])
    else $error("unused divide bits set");
  chk_div_readback: assert property (@(posedge clk) disable iff (!nrst)
    s_div_read |=> cmd_rvalid && cmd_rdata == $past(div_q))
    else $error("divide readback wrong");
  chk_asg_write: assert property (@(posedge clk) disable iff (!nrst)
    s_asg_write |=> asg_q == $past(cmd_wdata))
    else $error("assignment write lost");
  chk_asg_readback: assert property (@(posedge clk) disable iff (!nrst)
    s_asg_read |=> cmd_rvalid && cmd_rdata == $past(asg_q))
    else $error("assignment readback wrong");
  // Anything but the two read op-codes must leave the answer strobe low
  chk_no_answer: assert property (@(posedge clk) disable iff (!nrst)
    !(cmd_valid && (cmd_opcode == DIVIDER_READ_OPCODE || cmd_opcode == ASSIGNMENT_READ_OPCODE))
    |=> !cmd_rvalid)
    else $error("answer strobe without a read");
  chk_master_clear: assert property (@(posedge clk) disable iff (!nrst)
    master_clr |=> div_q == DIV_RESET && asg_q == ASSIGN_RESET)
    else $error("master reset did not clear");
  chk_soft_keep: assert property (@(posedge clk) disable iff (!nrst)
    (soft_reset && !master_clr && !cmd_valid) |=> $stable(asg_q) && $stable(div_q))
    else $error("soft reset changed settings");
  chk_tick_ratio: assert property (@(posedge clk) disable iff (!nrst)
    (div_q == 8'h00 && ref_rise && !master_clr && !cmd_valid) |=> timebase_tick)
    else $error("timebase missed at ratio one");
  chk_tick_single: assert property (@(posedge clk) disable iff (!nrst)
    timebase_tick |=> !timebase_tick)
    else $error("timebase tick longer than one cycle");
  // A master reset restarts the edge count, so no tick may follow it directly
  chk_tick_held: assert property (@(posedge clk) disable iff (!nrst)
    master_clr |=> !timebase_tick)
    else $error("timebase ticked after master reset");
endmodule : cdf_top

// ===== verification/cdf_host_model.sv
// Host side model: issues decoded commands and supplies the reference clock
`timescale 1ns/1ns
module cdf_host_model (
  // Clock
  input wire logic clk,
  input wire logic [7:0] ref_half,
  // Command port
  output logic cmd_valid,
  output logic [7:0] cmd_opcode,
  output logic [7:0] cmd_wdata,
  // Reference clock
  output logic ref_clk_in
);
  logic [7:0] ph_q;
  initial begin
    cmd_valid = 1'b0;
    cmd_opcode = 8'h00;
    cmd_wdata = 8'h00;
    ref_clk_in = 1'b0;
    ph_q = 8'h00;
  end
  // Reference toggles every ref_half clocks; zero holds it still at its last level
  always @(posedge clk) begin
    if (ref_half == 8'h00) begin
      ph_q <= 8'h00;
    end else if (ph_q + 8'h01 >= ref_half) begin
      ph_q <= 8'h00;
      ref_clk_in <= ~ref_clk_in;
    end else begin
      ph_q <= ph_q + 8'h01;
    end
  end
  // One command per call; released fields show inverted garbage
  task automatic send(input logic [7:0] op, input logic [7:0] wd);
    @(posedge clk);
    cmd_valid <= 1'b1;
    cmd_opcode <= op;
    cmd_wdata <= wd;
    @(posedge clk);
    cmd_valid <= 1'b0;
    cmd_opcode <= ~op;
    cmd_wdata <= ~wd;
  endtask : send
endmodule : cdf_host_model

// ===== verification/testbench.sv
// Self-checking bench for the divider and flag block
`timescale 1ns/1ns
module testbench;
  import cdf_pkg::*;
  logic clk, nrst, mrp, srst, cv, rv, tick, ev1, ev2, lp1, lp2, ref_clk;
  logic ws1, ws2;
  logic [7:0] op, wd, rd_q, div_s, asg_s, n, ref_half;
  logic [5:0] l1, l2;
  logic [2:0] mb1, mb2;
  logic [3:0] t;
  logic [15:0] dv [3] = '{16'hFF1E, 16'h0100, 16'h1C1C};
  logic [8:0] lv [8] = '{9'h001, 9'h002, 9'h0C1, 9'h0BE, 9'h121, 9'h11E, 9'h183, 9'h180};
  // Rows: reference half period in clocks, divide byte; both make a 1 us timebase
  logic [15:0] tb [2] = '{16'h3200, 16'h050A};
  int miscompares, n_checks, i, s, k;
  cdf_host_model i_host (.clk(clk), .ref_half(ref_half), .cmd_valid(cv), .cmd_opcode(op),
    .cmd_wdata(wd), .ref_clk_in(ref_clk));
  cdf_top i_dut (.clk(clk), .nrst(nrst), .master_reset_pin(mrp), .soft_reset(srst),
    .cmd_valid(cv), .cmd_opcode(op), .cmd_wdata(wd), .cmd_rdata(rd_q), .cmd_rvalid(rv),
    .ref_clk_in(ref_clk), .timebase_tick(tick), .rx_one_fifo_level(l1),
    .rx_one_word_stored(ws1), .rx_one_mailbox(mb1), .rx_two_fifo_level(l2),
    .rx_two_word_stored(ws2), .rx_two_mailbox(mb2), .rx_one_event_pin(ev1),
    .rx_two_event_pin(ev2), .rx_one_level_pin(lp1), .rx_two_level_pin(lp2),
    .clock_divide_setting(div_s), .flag_interrupt_assignment(asg_s));
  task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : cmp
  // Read answer lands one cycle after the command is taken and stands one cycle
  task automatic rd(input logic [7:0] opc, input logic [7:0] exp);
    i_host.send(opc, 8'h00);
    #1;
    cmp({7'h00, rv}, 8'h01);
    cmp(rd_q, exp);
    @(posedge clk);
    #1;
    cmp({7'h00, rv}, 8'h00);
  endtask : rd
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : report_and_stop
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    #200000;
    miscompares++;
    report_and_stop;
  end
  initial begin
    {nrst, mrp, srst, ref_half, ws1, ws2, mb1, mb2, l1, l2} = '0;
    repeat (4) @(posedge clk);
    nrst <= 1'b1;
    repeat (2) @(posedge clk);
    #1;
    cmp(div_s, DIV_RESET);
    cmp(asg_s, ASSIGN_RESET);
    cmp({6'h00, lp2, lp1}, 8'h03);
    for (i = 0; i < 3; i++) begin
      i_host.send(DIVIDER_WRITE_OPCODE, dv[i][15:8]);
      rd(DIVIDER_READ_OPCODE, dv[i][7:0]);
    end
    for (i = 0; i < 8; i++) begin
      i_host.send(ASSIGNMENT_WRITE_OPCODE, {2'b00, lv[i][8:7], 2'b00, lv[i][8:7]});
      l1 <= lv[i][6:1];
      l2 <= lv[i][6:1];
      repeat (3) @(posedge clk);
      #1;
      cmp({6'h00, lp2, lp1}, {6'h00, lv[i][0], lv[i][0]});
    end
    rd(ASSIGNMENT_READ_OPCODE, 8'h33);
    for (s = 0; s < 4; s++) for (k = 0; k < 4; k++) begin
      i_host.send(ASSIGNMENT_WRITE_OPCODE, {s[1:0], 2'b00, s[1:0], 2'b00});
      t = 4'h1 << k;
      {mb1, ws1} <= t;
      {mb2, ws2} <= t;
      @(posedge clk);
      {mb1, ws1, mb2, ws2} <= '0;
      @(posedge clk);
      #1;
      cmp({6'h00, ev2, ev1}, (s == 0 || s == k) ? 8'h03 : 8'h00);
      // The pin has already stood high for one cycle before this first look
      n = 8'h01;
      while (ev1 === 1'b1 && n < 8'd99) begin
        @(posedge clk);
        #1;
        n++;
      end
      if (s == k) cmp(n, PULSE_COUNT);
      repeat (55) @(posedge clk);
    end
    for (i = 0; i < 2; i++) begin
      ref_half <= tb[i][15:8];
      i_host.send(DIVIDER_WRITE_OPCODE, tb[i][7:0]);
      n = 8'h00;
      while (tick !== 1'b1 && n < 8'd200) begin
        @(posedge clk);
        #1;
        n++;
      end
      n = 8'h00;
      do begin
        @(posedge clk);
        #1;
        n++;
      end while (tick !== 1'b1 && n < 8'd200);
      cmp(n, 8'(TICK_CYCLES));
    end
    i_host.send(ASSIGNMENT_WRITE_OPCODE, 8'hFF);
    srst <= 1'b1;
    @(posedge clk);
    srst <= 1'b0;
    mrp <= 1'b1; // Settings must survive the soft reset just before
    #1;
    cmp(div_s, 8'h0A);
    cmp(asg_s, 8'hFF);
    @(posedge clk);
    mrp <= 1'b0;
    #1;
    cmp(asg_s | div_s, 8'h00);
    i_host.send(ASSIGNMENT_WRITE_OPCODE, 8'h5A);
    #1;
    cmp(asg_s, 8'h5A);
    i_host.send(MASTER_RESET_OPCODE, 8'h00);
    #1;
    cmp(asg_s, 8'h00);
    // An op-code this block does not decode gives no answer and changes nothing
    i_host.send(8'h99, 8'h00);
    #1;
    cmp({7'h00, rv}, 8'h00);
    cmp(asg_s | div_s, 8'h00);
    report_and_stop;
  end
endmodule : testbench
